/* File: adcsq_params.svh */
// constants for the converter sequencer and power control block
// assumes: included by the design file only, not by adcsq_pkg.sv, 40 MHz ref_clk
`ifndef ADCSQ_PARAMS_SVH
`define ADCSQ_PARAMS_SVH
`define ADCSQ_NUM_CH 16
`define ADCSQ_WORD_BITS 16
`define ADCSQ_CTRL_BITS 12
`define ADCSQ_TRACK_EDGE 5'h0E
`define ADCSQ_CTRL_EDGE 5'h0C
`define ADCSQ_LAST_EDGE 5'h10
`define ADCSQ_CTRL_RESET 12'hFFF
`define ADCSQ_MASK_RESET 16'h0000
`define ADCSQ_FIFO_DEPTH 4
// control word bit positions (update flag at bit 11)
`define ADCSQ_B_WRITE 11
`define ADCSQ_B_SEQ 10
`define ADCSQ_B_ADDR_HI 9
`define ADCSQ_B_ADDR_LO 6
`define ADCSQ_B_PM1 5
`define ADCSQ_B_PM0 4
`define ADCSQ_B_MASKSEL 3
`define ADCSQ_B_WEAK 2
// wake time in ns and its cycle count, rounded up
`define ADCSQ_WAKE_NS 1000
`define ADCSQ_CLK_NS 25
`define ADCSQ_WAKE_CYC ((`ADCSQ_WAKE_NS + `ADCSQ_CLK_NS - 1) / `ADCSQ_CLK_NS)
`endif

/* File: adcsq_pkg.sv */
// types for the converter sequencer and power control block
// assumes: nothing beyond the params header
package adcsq_pkg;
   typedef enum logic [3:0] {
      ADCSQ_PWR_ON = 4'h1,
      ADCSQ_PWR_FULL_OFF = 4'h2,
      ADCSQ_PWR_AUTO_OFF = 4'h4,
      ADCSQ_PWR_STANDBY = 4'h8
   } adcsq_pwr_e;
   typedef enum logic [2:0] {
      ADCSQ_SEQ_NONE = 3'h1,
      ADCSQ_SEQ_MASK = 3'h2,
      ADCSQ_SEQ_RANGE = 3'h4
   } adcsq_seq_e;
endpackage : adcsq_pkg

/* File: adcsq_top.sv */
// sequencer, register loading and power control of a serial converter
// assumes: link pins are asynchronous to ref_clk, conversion result is
// supplied by the analog side on sample_data, results stream out via fifo
`timescale 1ns/1ps
`include "adcsq_params.svh"

module adcsq_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q, rd_q;
   logic [AW:0] cnt_q;
   logic push, pop;

   // handshake terms
   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // storage and pointers
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else if (clk_en)
      begin
         if (push)
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
         if (pop)
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
         if (push && !pop)
            cnt_q <= cnt_q + (AW+1)'(1);
         else if (pop && !push)
            cnt_q <= cnt_q - (AW+1)'(1);
      end
   end

   // array write, no reset needed for data
   always_ff @(posedge ref_clk)
   begin
      if (clk_en && push)
         mem_q[wr_q] <= in_data;
   end
endmodule : adcsq_fifo

module adcsq_top (
   // clock, reset, enable
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clk_en,
   // serial link pins
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic din,
   output logic dout,
   output logic dout_oe,
   output logic dout_weak,
   // analog side
   input wire logic [11:0] sample_data,
   output logic [3:0] mux_sel,
   output logic track_hold,
   output logic powered,
   output logic bias_on,
   output logic conv_start,
   // result stream
   output logic [15:0] res_data,
   output logic res_valid,
   input wire logic res_ready,
   output logic res_overflow,
   // status
   output logic [11:0] ctrl_word,
   output logic [15:0] chan_mask,
   output logic [3:0] pwr_state,
   output logic seq_active
);
   // synchronisers
   logic [1:0] cs_s_q, sclk_s_q, din_s_q;
   logic cs_d1_q, sclk_d1_q;
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cs_s_q <= 2'h3;
         sclk_s_q <= 2'h3;
         din_s_q <= 2'h0;
         cs_d1_q <= 1'b1;
         sclk_d1_q <= 1'b1;
      end
      else if (clk_en)
      begin
         cs_s_q <= {cs_s_q[0], cs_n};
         sclk_s_q <= {sclk_s_q[0], sclk};
         din_s_q <= {din_s_q[0], din};
         cs_d1_q <= cs_s_q[1];
         sclk_d1_q <= sclk_s_q[1];
      end
   end
   logic cs_fall, cs_rise, sclk_fall, cs_low;
   assign cs_low = !cs_s_q[1];
   assign cs_fall = clk_en && cs_d1_q && !cs_s_q[1];
   assign cs_rise = clk_en && !cs_d1_q && cs_s_q[1];
   assign sclk_fall = clk_en && cs_low && sclk_d1_q && !sclk_s_q[1];

   // edge count and serial shift in
   logic [4:0] edge_q;
   logic [15:0] sh_in_q;
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         edge_q <= '0;
         sh_in_q <= '0;
      end
      else if (cs_fall || cs_rise)
         edge_q <= '0;
      else if (sclk_fall && edge_q != `ADCSQ_LAST_EDGE)
      begin
         edge_q <= edge_q + 5'h01;
         sh_in_q <= {sh_in_q[14:0], din_s_q[1]};
      end
   end

   // control and mask registers
   logic [11:0] ctrl_q;
   logic [15:0] mask_q;
   logic mask_next_q, mask_xfer_q, ctrl_upd_q, ctrl_now;
   assign ctrl_now = sclk_fall && edge_q == (`ADCSQ_CTRL_EDGE - 5'h01) && !mask_xfer_q;
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ctrl_q <= `ADCSQ_CTRL_RESET;
         mask_q <= `ADCSQ_MASK_RESET;
         mask_next_q <= 1'b0;
         mask_xfer_q <= 1'b0;
         ctrl_upd_q <= 1'b0;
      end
      else
      begin
         if (cs_fall)
         begin
            mask_xfer_q <= mask_next_q;
            mask_next_q <= 1'b0;
            ctrl_upd_q <= 1'b0;
         end
         // first bit is the update flag, 12 bits into control
         if (ctrl_now && sh_in_q[`ADCSQ_B_WRITE - 1])
         begin
            ctrl_q <= {sh_in_q[`ADCSQ_CTRL_BITS - 2:0], din_s_q[1]};
            ctrl_upd_q <= 1'b1;
            mask_next_q <= !sh_in_q[`ADCSQ_B_SEQ - 1] && sh_in_q[`ADCSQ_B_MASKSEL - 1];
         end
         // mask loads on all 16 edges, takes effect at select rise
         if (cs_rise && mask_xfer_q && edge_q == `ADCSQ_LAST_EDGE)
         begin
            mask_q <= sh_in_q;
            mask_xfer_q <= 1'b0;
         end
      end
   end

   // sequencer
   adcsq_pkg::adcsq_seq_e seq_q;
   logic [3:0] chan_q, next_mask_ch, first_mask_ch;
   logic seq_restart_q, found_next;
   always_comb
   begin
      next_mask_ch = '0;
      first_mask_ch = '0;
      found_next = 1'b0;
      for (int i = `ADCSQ_NUM_CH - 1; i >= 0; i--)
      begin
         if (mask_q[i])
            first_mask_ch = 4'(i);
         if (mask_q[i] && 4'(i) > chan_q)
         begin
            next_mask_ch = 4'(i);
            found_next = 1'b1;
         end
      end
   end
   logic [3:0] addr_bits;
   assign addr_bits = ctrl_q[`ADCSQ_B_ADDR_HI:`ADCSQ_B_ADDR_LO];
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         seq_q <= adcsq_pkg::ADCSQ_SEQ_NONE;
         chan_q <= '0;
         seq_restart_q <= 1'b0;
      end
      else if (cs_rise)
      begin
         if (mask_xfer_q)
         begin
            seq_q <= adcsq_pkg::ADCSQ_SEQ_MASK;
            seq_restart_q <= 1'b1;
         end
         else if (ctrl_upd_q)
         begin
            // only 1,0 keeps a running sequence alive
            if (ctrl_q[`ADCSQ_B_SEQ] && !ctrl_q[`ADCSQ_B_MASKSEL])
               seq_q <= seq_q;
            else if (ctrl_q[`ADCSQ_B_SEQ] && ctrl_q[`ADCSQ_B_MASKSEL])
            begin
               seq_q <= adcsq_pkg::ADCSQ_SEQ_RANGE;
               seq_restart_q <= 1'b1;
            end
            else
               seq_q <= adcsq_pkg::ADCSQ_SEQ_NONE;
         end
      end
      else if (cs_fall)
      begin
         // pick channel for this conversion
         seq_restart_q <= 1'b0;
         case (seq_q)
            adcsq_pkg::ADCSQ_SEQ_MASK:
               if (seq_restart_q || !found_next)
                  chan_q <= first_mask_ch;
               else
                  chan_q <= next_mask_ch;
            adcsq_pkg::ADCSQ_SEQ_RANGE:
               if (seq_restart_q || chan_q >= addr_bits)
                  chan_q <= '0;
               else
                  chan_q <= chan_q + 4'h1;
            default:
               chan_q <= addr_bits;
         endcase
      end
   end

   // power mode machine
   adcsq_pkg::adcsq_pwr_e pwr_q;
   logic [5:0] wake_q;
   logic [1:0] pm_bits;
   assign pm_bits = {ctrl_q[`ADCSQ_B_PM1], ctrl_q[`ADCSQ_B_PM0]};
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pwr_q <= adcsq_pkg::ADCSQ_PWR_ON;
         wake_q <= '0;
      end
      else if (clk_en)
      begin
         if (wake_q != 6'h00)
            wake_q <= wake_q - 6'h01;
         if (cs_rise)
         begin
            // mode applied at end of the conversion
            case (pm_bits)
               2'b11: pwr_q <= adcsq_pkg::ADCSQ_PWR_ON;
               2'b10: pwr_q <= adcsq_pkg::ADCSQ_PWR_FULL_OFF;
               2'b01: pwr_q <= adcsq_pkg::ADCSQ_PWR_AUTO_OFF;
               default: pwr_q <= adcsq_pkg::ADCSQ_PWR_STANDBY;
            endcase
         end
         else if (cs_fall && (pwr_q == adcsq_pkg::ADCSQ_PWR_AUTO_OFF ||
                              pwr_q == adcsq_pkg::ADCSQ_PWR_STANDBY))
            wake_q <= 6'(`ADCSQ_WAKE_CYC);
      end
   end

   // track and hold, conversion start
   logic th_q, start_q, auto_mode;
   assign auto_mode = (pwr_q == adcsq_pkg::ADCSQ_PWR_AUTO_OFF);
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         th_q <= 1'b1;
         start_q <= 1'b0;
      end
      else if (clk_en)
      begin
         start_q <= cs_fall;
         if (cs_fall)
            th_q <= auto_mode || pwr_q == adcsq_pkg::ADCSQ_PWR_STANDBY;
         else if (sclk_fall && edge_q == `ADCSQ_TRACK_EDGE - 5'h01 && !mask_xfer_q)
            th_q <= 1'b1;
         else if (cs_rise && mask_xfer_q)
            th_q <= 1'b1;
         else if (cs_rise && (pm_bits == 2'b01 || pm_bits == 2'b00))
            th_q <= 1'b0; // hold while asleep
      end
   end

   // output shifter, address then result
   logic [15:0] sh_out_q, res_word;
   logic oe_q, weak_q;
   assign res_word = {chan_q, sample_data};
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sh_out_q <= '0;
         oe_q <= 1'b0;
         weak_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (start_q)
         begin
            sh_out_q <= res_word;
            oe_q <= 1'b1;
            weak_q <= 1'b0;
         end
         else if (sclk_fall && edge_q == `ADCSQ_LAST_EDGE - 5'h01)
         begin
            oe_q <= 1'b0;
            weak_q <= ctrl_q[`ADCSQ_B_WEAK];
         end
         else if (sclk_fall)
            sh_out_q <= {sh_out_q[14:0], 1'b0};
      end
   end

   // result stream through fifo
   logic push_q, fifo_in_ready;
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         push_q <= 1'b0;
         res_overflow <= 1'b0;
      end
      else if (clk_en)
      begin
         push_q <= sclk_fall && edge_q == `ADCSQ_LAST_EDGE - 5'h01;
         if (push_q && !fifo_in_ready)
            res_overflow <= 1'b1;
         else if (cs_fall)
            res_overflow <= 1'b0;
      end
   end

   logic [15:0] f_data;
   logic f_valid, take;
   adcsq_fifo #(.WIDTH(`ADCSQ_WORD_BITS), .DEPTH(`ADCSQ_FIFO_DEPTH)) u_fifo (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .clk_en(clk_en),
      .in_data(res_word),
      .in_valid(push_q),
      .in_ready(fifo_in_ready),
      .out_data(f_data),
      .out_valid(f_valid),
      .out_ready(take)
   );
   // register stage after the fifo
   assign take = clk_en && (!res_valid || res_ready);
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         res_valid <= 1'b0;
         res_data <= '0;
      end
      else if (take)
      begin
         res_valid <= f_valid;
         res_data <= f_data;
      end
   end

   // registered status and pins
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         dout <= 1'b0;
         dout_oe <= 1'b0;
         dout_weak <= 1'b0;
         mux_sel <= '0;
         track_hold <= 1'b1;
         powered <= 1'b1;
         bias_on <= 1'b1;
         conv_start <= 1'b0;
         ctrl_word <= `ADCSQ_CTRL_RESET;
         chan_mask <= `ADCSQ_MASK_RESET;
         pwr_state <= adcsq_pkg::ADCSQ_PWR_ON;
         seq_active <= 1'b0;
      end
      else if (clk_en)
      begin
         dout <= sh_out_q[15];
         dout_oe <= oe_q;
         dout_weak <= weak_q && !oe_q;
         mux_sel <= chan_q;
         track_hold <= th_q;
         // full shutdown stays dark even while a frame runs
         powered <= pwr_q == adcsq_pkg::ADCSQ_PWR_ON ||
            (pwr_q != adcsq_pkg::ADCSQ_PWR_FULL_OFF && (wake_q != 6'h00 || cs_low));
         bias_on <= pwr_q != adcsq_pkg::ADCSQ_PWR_FULL_OFF && !(auto_mode && !cs_low);
         conv_start <= start_q;
         ctrl_word <= ctrl_q;
         chan_mask <= mask_q;
         pwr_state <= pwr_q;
         seq_active <= seq_q != adcsq_pkg::ADCSQ_SEQ_NONE;
      end
   end
endmodule : adcsq_top

/* File: adcsq_properties.sv */
// checker on the converter control top: link timing, power, result stream
// assumes: bound to adcsq_top, link pins asynchronous to ref_clk
`timescale 1ns/1ps
module adcsq_checker (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // link pins
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic dout_oe,
   // analog side
   input wire logic track_hold,
   input wire logic powered,
   input wire logic bias_on,
   input wire logic conv_start,
   // result stream
   input wire logic [15:0] res_data,
   input wire logic res_valid,
   input wire logic res_ready,
   // status
   input wire logic [11:0] ctrl_word,
   input wire logic [15:0] chan_mask,
   input wire logic [3:0] pwr_state
);
   logic [2:0] sck_q;
   logic [1:0] cs_q;
   logic [4:0] cnt_q;
   logic [3:0] idle_q;
   logic sfall;
   assign sfall = sck_q[2] & ~sck_q[1];
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);
   // pin synchronisers
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sck_q <= 3'h7;
         cs_q <= 2'h3;
      end
      else
      begin
         sck_q <= {sck_q[1:0], sclk};
         cs_q <= {cs_q[0], cs_n};
      end
   end
   // sclk falls since select fell
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         cnt_q <= 5'h00;
      else if (cs_q[1])
         cnt_q <= 5'h00;
      else if (sfall && cnt_q != 5'h10)
         cnt_q <= cnt_q + 5'h01;
   end
   // cycles of select high, saturating
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         idle_q <= 4'h0;
      else if (!cs_q[1])
         idle_q <= 4'h0;
      else if (idle_q != 4'hF)
         idle_q <= idle_q + 4'h1;
   end
   sequence s_cs_fall;
      $fell(cs_n) && pwr_state != adcsq_pkg::ADCSQ_PWR_FULL_OFF;
   endsequence
   sequence s_edge14;
      sfall && cnt_q == 5'h0D && pwr_state == adcsq_pkg::ADCSQ_PWR_ON
         && !(!ctrl_word[10] && ctrl_word[3]);
   endsequence
   property p_conv_start;
      s_cs_fall |-> ##[1:6] conv_start;
   endproperty
   a_conv_start: assert property (p_conv_start) else $error("no start pulse");
   property p_oe_on;
      s_cs_fall |-> ##[1:8] dout_oe;
   endproperty
   a_oe_on: assert property (p_oe_on) else $error("output not driven");
   property p_oe_off;
      sfall && cnt_q == 5'h0F |-> ##[0:8] !dout_oe;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("output not released");
   property p_track14;
      s_edge14 |-> ##[0:8] track_hold;
   endproperty
   a_track14: assert property (p_track14) else $error("no track at edge 14");
   property p_res_hold;
      res_valid && !res_ready |=> res_valid && $stable(res_data);
   endproperty
   a_res_hold: assert property (p_res_hold) else $error("result dropped");
   property p_onehot;
      $onehot(pwr_state);
   endproperty
   a_onehot: assert property (p_onehot) else $error("power state bad");
   property p_full_off;
      pwr_state == adcsq_pkg::ADCSQ_PWR_FULL_OFF
         && $past(pwr_state) == adcsq_pkg::ADCSQ_PWR_FULL_OFF |-> !powered && !bias_on;
   endproperty
   a_full_off: assert property (p_full_off) else $error("powered in shutdown");
   property p_standby;
      pwr_state == adcsq_pkg::ADCSQ_PWR_STANDBY
         && $past(pwr_state) == adcsq_pkg::ADCSQ_PWR_STANDBY |-> bias_on;
   endproperty
   a_standby: assert property (p_standby) else $error("bias off in standby");
   property p_ctrl_keep;
      idle_q == 4'hF |-> $stable(ctrl_word) && $stable(chan_mask);
   endproperty
   a_ctrl_keep: assert property (p_ctrl_keep) else $error("register moved idle");
   property p_auto_off;
      pwr_state == adcsq_pkg::ADCSQ_PWR_AUTO_OFF && idle_q == 4'hF |-> !powered && !track_hold;
   endproperty
   a_auto_off: assert property (p_auto_off) else $error("awake in auto off");
endmodule : adcsq_checker

bind adcsq_top adcsq_checker u_adcsq_checker (.ref_clk, .resetn, .cs_n, .sclk, .dout_oe,
   .track_hold, .powered, .bias_on, .conv_start, .res_data, .res_valid, .res_ready,
   .ctrl_word, .chan_mask, .pwr_state);

/* File: adcsq_host_model.sv */
// host end of the four-wire link, one task call per frame
// assumes: sclk idles high between frames, 200 ns sclk period
`timescale 1ns/1ps
module adcsq_host_model #(
   parameter int HALF_NS = 100,
   parameter int GAP_NS = 500
) (
   // link pins
   output logic cs_n,
   output logic sclk,
   output logic din,
   input wire logic dout,
   input wire logic dout_oe
);
   // select idles high, clock still
   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b1;
      din = 1'b0;
   end
   // one frame msb first; a released line reads inverted
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      int i;
      rx = 16'h0000;
      cs_n = 1'b0;
      #(HALF_NS);
      for (i = 15; i >= 0; i--)
      begin
         din = tx[i];
         #(HALF_NS);
         rx[i] = dout_oe ? dout : ~dout;
         sclk = 1'b0;
         #(HALF_NS);
         sclk = 1'b1;
      end
      cs_n = 1'b1;
      din = ~din;
      #(GAP_NS); // quiet gap
   endtask : xfer
endmodule : adcsq_host_model

/* File: tb_top.sv */
// bench: host model frames, result fifo drained and checked
// assumes: design and host model compiled first
`timescale 1ns/1ps
module tb_top;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic clk_en = 1'b1;
   logic res_ready = 1'b0;
   logic [11:0] sample_data = 12'h000;
   logic cs_n, sclk, din, dout, dout_oe, dout_weak, track_hold, powered, bias_on;
   logic conv_start, res_valid, res_overflow, seq_active;
   logic [3:0] mux_sel, pwr_state;
   logic [15:0] res_data, chan_mask, w;
   logic [11:0] ctrl_word, smp = 12'h3A5;
   logic [15:0] exp_q[$];
   logic [3:0] mch[5] = '{4'h1, 4'h6, 4'h9, 4'hB, 4'h1};
   logic [3:0] rch[4] = '{4'h0, 4'h1, 4'h2, 4'h0};
   int fails = 0;
   int checks_done = 0;
   int cyc = 0;
   adcsq_top u_adcsq_top (.ref_clk, .resetn, .clk_en, .cs_n, .sclk, .din, .dout, .dout_oe,
      .dout_weak, .sample_data, .mux_sel, .track_hold, .powered, .bias_on, .conv_start,
      .res_data, .res_valid, .res_ready, .res_overflow, .ctrl_word, .chan_mask,
      .pwr_state, .seq_active);
   adcsq_host_model u_adcsq_host_model (.cs_n, .sclk, .din, .dout, .dout_oe);
   // clock and hang limit
   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         fails++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_of_test
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string m);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk_word
   task automatic chk_bit(input logic got, input logic exp, input string m);
      chk_word({15'h0000, got}, {15'h0000, exp}, m);
   endtask : chk_bit
   function automatic logic [15:0] cw(input logic sq, input logic [3:0] a,
      input logic [1:0] pm, input logic ms, input logic wk);
      return {1'b1, sq, a, pm, ms, wk, 6'h00};
   endfunction : cw
   task automatic chk_pwr(input logic [3:0] st, input logic pw);
      chk_word({12'h000, pwr_state}, {12'h000, st}, "power state");
      chk_bit(powered, pw, "powered");
   endtask : chk_pwr
   // take one result from the fifo, bounded wait
   task automatic pop(input logic chk, input logic [15:0] exp);
      int n;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end while (res_valid !== 1'b1 && n < 60);
      if (res_valid === 1'b1)
      begin
         if (chk)
            chk_word(res_data, exp, "result");
         res_ready = 1'b1;
         @(posedge ref_clk);
         #1 res_ready = 1'b0;
      end
      else if (chk)
         chk_bit(1'b0, 1'b1, "no result");
   endtask : pop
   // one frame: new sample, serial word checked, result popped or queued
   task automatic xfer(input logic [15:0] x, input logic chk, input logic [3:0] ch,
      input logic take);
      logic [15:0] rx;
      @(posedge ref_clk);
      #1 smp = smp + 12'h137;
      sample_data = smp;
      u_adcsq_host_model.xfer(x, rx);
      if (chk)
         chk_word(rx, {ch, smp}, "serial word");
      if (take)
         pop(chk, {ch, smp});
      else
         exp_q.push_back({ch, smp});
   endtask : xfer
   // main sequence
   initial
   begin
      repeat (5) @(posedge ref_clk);
      #1 resetn = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1 chk_word({4'h0, ctrl_word}, 16'h0FFF, "reset ctrl");
      chk_word(chan_mask, 16'h0000, "reset mask");
      chk_pwr(adcsq_pkg::ADCSQ_PWR_ON, 1'b1);
      repeat (2) xfer(16'hFFFF, 1'b0, 4'h0, 1'b1);
      xfer(cw(1'b0, 4'h5, 2'h3, 1'b0, 1'b0), 1'b0, 4'h0, 1'b1);
      w = cw(1'b0, 4'h9, 2'h3, 1'b0, 1'b0);
      xfer(w, 1'b1, 4'h5, 1'b1);
      chk_word({4'h0, ctrl_word}, {4'h0, w[15:4]}, "ctrl");
      chk_word({12'h000, mux_sel}, {12'h000, 4'h5}, "mux");
      chk_bit(dout_oe, 1'b0, "released");
      xfer(16'h0000, 1'b1, 4'h9, 1'b1);
      chk_word({4'h0, ctrl_word}, {4'h0, w[15:4]}, "ctrl kept");
      xfer(cw(1'b0, 4'h0, 2'h3, 1'b1, 1'b0), 1'b1, 4'h9, 1'b1);
      xfer(16'h0A42, 1'b0, 4'h0, 1'b1);
      chk_word(chan_mask, 16'h0A42, "mask");
      foreach (mch[i]) xfer(16'h0000, 1'b1, mch[i], 1'b1);
      chk_bit(seq_active, 1'b1, "seq on");
      xfer(cw(1'b1, 4'h0, 2'h3, 1'b0, 1'b0), 1'b1, 4'h6, 1'b1);
      xfer(16'h0000, 1'b1, 4'h9, 1'b1);
      xfer(cw(1'b0, 4'h3, 2'h3, 1'b0, 1'b0), 1'b1, 4'hB, 1'b1);
      xfer(16'h0000, 1'b1, 4'h3, 1'b1);
      chk_bit(seq_active, 1'b0, "seq off");
      xfer(cw(1'b1, 4'h2, 2'h3, 1'b1, 1'b0), 1'b1, 4'h3, 1'b1);
      foreach (rch[i]) xfer(16'h0000, 1'b1, rch[i], 1'b1);
      w = cw(1'b0, 4'h4, 2'h2, 1'b0, 1'b0);
      xfer(w, 1'b0, 4'h0, 1'b1);
      chk_pwr(adcsq_pkg::ADCSQ_PWR_FULL_OFF, 1'b0);
      xfer(16'h0000, 1'b0, 4'h0, 1'b1);
      chk_pwr(adcsq_pkg::ADCSQ_PWR_FULL_OFF, 1'b0);
      chk_word({4'h0, ctrl_word}, {4'h0, w[15:4]}, "ctrl held");
      xfer(cw(1'b0, 4'h4, 2'h3, 1'b0, 1'b0), 1'b0, 4'h0, 1'b1);
      repeat (48) @(posedge ref_clk); // power_up_delay
      #1 chk_pwr(adcsq_pkg::ADCSQ_PWR_ON, 1'b1);
      xfer(cw(1'b0, 4'h4, 2'h1, 1'b0, 1'b0), 1'b1, 4'h4, 1'b1);
      chk_pwr(adcsq_pkg::ADCSQ_PWR_AUTO_OFF, 1'b0);
      chk_bit(track_hold, 1'b0, "held");
      xfer(16'h0000, 1'b0, 4'h4, 1'b1);
      xfer(16'h0000, 1'b1, 4'h4, 1'b1);
      chk_bit(powered, 1'b0, "auto off");
      xfer(cw(1'b0, 4'h4, 2'h0, 1'b0, 1'b0), 1'b1, 4'h4, 1'b1);
      chk_pwr(adcsq_pkg::ADCSQ_PWR_STANDBY, 1'b0);
      chk_bit(bias_on, 1'b1, "bias");
      chk_bit(track_hold, 1'b0, "standby hold");
      w = cw(1'b0, 4'h7, 2'h3, 1'b0, 1'b1);
      xfer(w, 1'b1, 4'h4, 1'b1);
      chk_bit(dout_weak, 1'b1, "weak");
      chk_bit(dout_oe, 1'b0, "no strong");
      repeat (6) xfer(w, 1'b1, 4'h7, 1'b0);
      chk_bit(res_overflow, 1'b1, "overflow");
      repeat (5) pop(1'b1, exp_q.pop_front());
      @(posedge ref_clk);
      #1 chk_bit(res_valid, 1'b0, "empty");
      xfer(16'h0000, 1'b1, 4'h7, 1'b1);
      chk_bit(res_overflow, 1'b0, "overflow clear");
      end_of_test();
   end
endmodule : tb_top
